// File: rtl/side_consts.svh
`ifndef SIDE_CONSTS_SVH
`define SIDE_CONSTS_SVH
// register byte offsets on the apb
`define SIDE_OFF_XLAT     12'h000
`define SIDE_OFF_BUF      12'h004
`define SIDE_OFF_EXEC     12'h008
`define SIDE_OFF_USTAT    12'h00C
`define SIDE_OFF_CTRL     12'h010
`define SIDE_OFF_IRQ_STAT 12'h014
`define SIDE_OFF_IRQ_MASK 12'h018
// translator word fields
`define SIDE_HUB_MSB      31
`define SIDE_HUB_LSB      25
`define SIDE_PORT_MSB     24
`define SIDE_PORT_LSB     18
// buffer word fields
`define SIDE_BUF_MSB      23
`define SIDE_BUF_LSB      8
`define SIDE_UFR_MSB      7
`define SIDE_UFR_POLL_LSB 3
// execution word fields
`define SIDE_ACT_BIT      31
`define SIDE_HALT_BIT     30
`define SIDE_BAB_BIT      29
`define SIDE_XERR_BIT     28
`define SIDE_SC_BIT       27
`define SIDE_DT_BIT       25
`define SIDE_CERR_MSB     24
`define SIDE_CERR_LSB     23
`define SIDE_BYTES_MSB    11
// per-microframe result field layout
`define SIDE_RES_W        3
`define SIDE_RES_LSB      8
`define SIDE_RES_ERR      0
`define SIDE_RES_BAB      1
`define SIDE_RES_UNDER    2
`define SIDE_SSM_MSB      7
// interrupt bits
`define SIDE_IRQ_DONE     0
`define SIDE_IRQ_HALT     1
`define SIDE_IRQ_XERR     2
// misc values
`define SIDE_EXP_BASE     4'h4
`define SIDE_CERR_ONE     2'h1
`define SIDE_CERR_RST     2'h3
`endif

// File: rtl/side_pkg.sv
package side_pkg;
  typedef enum logic [0:0] {SIDE_IDLE, SIDE_WAIT} side_state_t;
endpackage

// File: rtl/side_exec.sv
// What this block does
// - halted set on stall in any microframe
// - babble flag mirrors result field bit one
// - error flag mirrors result field bit zero
// - toggle preloaded, flipped by each completed transaction
// - error counter writable by software and hardware
// - try three times, then report transaction error
// - twelve-bit count of bytes really transferred
// - buffer address is an internal memory address
// - run every two to b-1 microframes
// - result bits: error, babble, underrun
// - start-split mask bits cleared after use
// - valid flag cleared once descriptor executed
`timescale 1ns/100ps
`include "side_consts.svh"
module side_exec (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESETN,
  input  wire logic        i_PSEL,
  input  wire logic        i_PENABLE,
  input  wire logic        i_PWRITE,
  input  wire logic [11:0] i_PADDR,
  input  wire logic [31:0] i_PWDATA,
  output logic      [31:0] o_PRDATA,
  output logic             o_PREADY,
  output logic             o_PSLVERR,
  input  wire logic        i_UFRAME_TICK,
  input  wire logic        i_RES_VALID,
  input  wire logic        i_RES_ERR,
  input  wire logic        i_RES_BABBLE,
  input  wire logic        i_RES_UNDERRUN,
  input  wire logic        i_RES_STALL,
  input  wire logic [11:0] i_RES_BYTES,
  output logic             o_TXN_REQ,
  output logic             o_TXN_COMPLETE,
  output logic             o_TXN_TOGGLE,
  output logic      [6:0]  o_TXN_HUB_ADDR,
  output logic      [6:0]  o_TXN_PORT_NUM,
  output logic      [15:0] o_TXN_BUF_ADDR,
  output logic             o_IRQ
);

  // descriptor, engine and bus state
  logic [6:0]  translator_hub_addr_r, translator_hub_addr_nxt;
  logic [6:0]  translator_port_num_r, translator_port_num_nxt;
  logic [15:0] buffer_start_addr_r,   buffer_start_addr_nxt;
  logic [7:0]  ufr_r,                 ufr_nxt;
  logic        act_r,                 act_nxt;
  logic        halt_r,                halt_nxt;
  logic        bab_r,                 bab_nxt;
  logic        xerr_r,                xerr_nxt;
  logic        split_phase_bit_r,     split_phase_bit_nxt;
  logic        toggle_bit_r,          toggle_bit_nxt;
  logic [1:0]  cerr_r,                cerr_nxt;
  logic [11:0] bytes_done_count_r,    bytes_done_count_nxt;
  logic [23:0] res_r,                 res_nxt;
  logic [7:0]  start_split_mask_r,    start_split_mask_nxt;
  logic        vld_r,                 vld_nxt;
  logic [2:0]  irq_st_r,              irq_st_nxt;
  logic [2:0]  irq_mk_r,              irq_mk_nxt;
  logic [13:0] ucnt_r,                ucnt_nxt;
  logic [2:0]  slot_r,                slot_nxt;
  logic        req_r,                 req_nxt;
  logic [31:0] rdata_r,               rdata_nxt;
  side_pkg::side_state_t st_r,        st_nxt;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [2:0]  ev;
  logic [2:0]  fld;

  // polling mask: interval of two to the b-1 microframes
  function automatic logic [7:0] poll_mask(input logic [7:0] f);
    logic [3:0] b;
    b = 4'h1;
    for (int i = 0; i < 5; i++) begin
      if (f[`SIDE_UFR_POLL_LSB + i]) begin
        b = 4'(`SIDE_EXP_BASE + 4'(i));
      end
    end
    poll_mask = 8'((9'h001 << (b - 4'h1)) - 9'h001);
  endfunction

  // address decode shared by write and error answer
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `SIDE_OFF_XLAT) || (a == `SIDE_OFF_BUF) ||
             (a == `SIDE_OFF_EXEC) || (a == `SIDE_OFF_USTAT) ||
             (a == `SIDE_OFF_CTRL) || (a == `SIDE_OFF_IRQ_STAT) ||
             (a == `SIDE_OFF_IRQ_MASK);
  endfunction

  // register read view
  function automatic logic [31:0] rd_view(input logic [11:0] a);
    rd_view = 32'h0000_0000;
    case (a)
      `SIDE_OFF_XLAT: begin
        rd_view[`SIDE_HUB_MSB:`SIDE_HUB_LSB]   = translator_hub_addr_r;
        rd_view[`SIDE_PORT_MSB:`SIDE_PORT_LSB] = translator_port_num_r;
      end
      `SIDE_OFF_BUF: begin
        rd_view[`SIDE_BUF_MSB:`SIDE_BUF_LSB] = buffer_start_addr_r;
        rd_view[`SIDE_UFR_MSB:0]             = ufr_r;
      end
      `SIDE_OFF_EXEC: begin
        rd_view[`SIDE_ACT_BIT]  = act_r;
        rd_view[`SIDE_HALT_BIT] = halt_r;
        rd_view[`SIDE_BAB_BIT]  = bab_r;
        rd_view[`SIDE_XERR_BIT] = xerr_r;
        rd_view[`SIDE_SC_BIT]   = split_phase_bit_r;
        rd_view[`SIDE_DT_BIT]   = toggle_bit_r;
        rd_view[`SIDE_CERR_MSB:`SIDE_CERR_LSB] = cerr_r;
        rd_view[`SIDE_BYTES_MSB:0]            = bytes_done_count_r;
      end
      `SIDE_OFF_USTAT: rd_view = {res_r, start_split_mask_r};
      `SIDE_OFF_CTRL:     rd_view[0]   = vld_r;
      `SIDE_OFF_IRQ_STAT: rd_view[2:0] = irq_st_r;
      `SIDE_OFF_IRQ_MASK: rd_view[2:0] = irq_mk_r;
      default: rd_view = 32'h0000_0000;
    endcase
  endfunction

  // apb handshake: zero wait states, error on unmapped address
  assign hit       = mapped(i_PADDR);
  assign wr_acc    = i_PSEL & i_PENABLE & i_PWRITE & hit;
  assign rd_acc    = i_PSEL & i_PENABLE & ~i_PWRITE;
  assign o_PREADY  = 1'b1;
  assign o_PSLVERR = i_PSEL & i_PENABLE & ~hit;
  assign o_PRDATA  = rdata_r;

  // next state of the descriptor and the split engine
  always_comb begin
    translator_hub_addr_nxt = translator_hub_addr_r;
    translator_port_num_nxt = translator_port_num_r;
    buffer_start_addr_nxt   = buffer_start_addr_r;
    ufr_nxt                 = ufr_r;
    act_nxt                 = act_r;
    halt_nxt                = halt_r;
    split_phase_bit_nxt     = split_phase_bit_r;
    toggle_bit_nxt          = toggle_bit_r;
    cerr_nxt                = cerr_r;
    bytes_done_count_nxt    = bytes_done_count_r;
    res_nxt                 = res_r;
    start_split_mask_nxt    = start_split_mask_r;
    vld_nxt                 = vld_r;
    irq_mk_nxt              = irq_mk_r;
    ucnt_nxt                = ucnt_r;
    slot_nxt                = slot_r;
    st_nxt                  = st_r;
    req_nxt                 = 1'b0;
    ev                      = 3'h0;
    fld                     = 3'h0;
    rdata_nxt = (i_PSEL & ~i_PENABLE) ? rd_view(i_PADDR) : rdata_r;
    // software writes first; hardware updates below take priority
    if (wr_acc) begin
      case (i_PADDR)
        `SIDE_OFF_XLAT: begin
          translator_hub_addr_nxt =
            i_PWDATA[`SIDE_HUB_MSB:`SIDE_HUB_LSB];
          translator_port_num_nxt =
            i_PWDATA[`SIDE_PORT_MSB:`SIDE_PORT_LSB];
        end
        `SIDE_OFF_BUF: begin
          buffer_start_addr_nxt =
            i_PWDATA[`SIDE_BUF_MSB:`SIDE_BUF_LSB];
          ufr_nxt = i_PWDATA[`SIDE_UFR_MSB:0];
        end
        `SIDE_OFF_EXEC: begin
          act_nxt             = i_PWDATA[`SIDE_ACT_BIT];
          split_phase_bit_nxt = i_PWDATA[`SIDE_SC_BIT];
          toggle_bit_nxt      = i_PWDATA[`SIDE_DT_BIT];
          cerr_nxt = i_PWDATA[`SIDE_CERR_MSB:`SIDE_CERR_LSB];
          halt_nxt            = 1'b0;
        end
        `SIDE_OFF_USTAT: begin
          res_nxt              = i_PWDATA[31:`SIDE_RES_LSB];
          start_split_mask_nxt = i_PWDATA[`SIDE_SSM_MSB:0];
        end
        `SIDE_OFF_CTRL:     vld_nxt    = i_PWDATA[0];
        `SIDE_OFF_IRQ_MASK: irq_mk_nxt = i_PWDATA[2:0];
        default: ;
      endcase
    end
    case (st_r)
      side_pkg::SIDE_IDLE: begin
        if (i_UFRAME_TICK) begin
          ucnt_nxt = ucnt_r + 14'h0001;
          // issue only on a polling slot of a live descriptor
          if (vld_r && act_r && !halt_r &&
              ((ucnt_r[7:0] & poll_mask(ufr_r)) == 8'h00) &&
              (split_phase_bit_r ||
               start_split_mask_r[ucnt_r[2:0]])) begin
            req_nxt  = 1'b1;
            slot_nxt = ucnt_r[2:0];
            st_nxt   = side_pkg::SIDE_WAIT;
          end
        end
      end
      side_pkg::SIDE_WAIT: begin
        if (i_RES_VALID) begin
          st_nxt = side_pkg::SIDE_IDLE;
          fld[`SIDE_RES_BAB]   = i_RES_BABBLE;
          fld[`SIDE_RES_UNDER] = i_RES_UNDERRUN;
          if (i_RES_STALL || i_RES_BABBLE) begin
            halt_nxt = 1'b1;
            act_nxt  = 1'b0;
            vld_nxt  = 1'b0;
            ev[`SIDE_IRQ_HALT] = 1'b1;
          end else if (i_RES_ERR) begin
            if (cerr_r > `SIDE_CERR_ONE) begin
              cerr_nxt = cerr_r - `SIDE_CERR_ONE;
            end else begin
              cerr_nxt = 2'h0;
              fld[`SIDE_RES_ERR] = 1'b1;
              act_nxt  = 1'b0;
              vld_nxt  = 1'b0;
              ev[`SIDE_IRQ_XERR] = 1'b1;
            end
          end else if (!split_phase_bit_r) begin
            split_phase_bit_nxt = 1'b1;
            start_split_mask_nxt[slot_r] = 1'b0;
          end else begin
            bytes_done_count_nxt = i_RES_BYTES;
            toggle_bit_nxt = ~toggle_bit_r;
            act_nxt  = 1'b0;
            vld_nxt  = 1'b0;
            ev[`SIDE_IRQ_DONE] = 1'b1;
          end
          res_nxt[slot_r*`SIDE_RES_W +: `SIDE_RES_W] = fld;
        end
      end
      default: st_nxt = side_pkg::SIDE_IDLE;
    endcase
    // summary flags follow the per-microframe result fields
    bab_nxt  = 1'b0;
    xerr_nxt = 1'b0;
    for (int k = 0; k < 8; k++) begin
      bab_nxt  = bab_nxt  | res_nxt[k*`SIDE_RES_W + `SIDE_RES_BAB];
      xerr_nxt = xerr_nxt | res_nxt[k*`SIDE_RES_W + `SIDE_RES_ERR];
    end
    // sticky events; a new event wins over the read clear
    irq_st_nxt = irq_st_r;
    if (rd_acc && (i_PADDR == `SIDE_OFF_IRQ_STAT)) begin
      irq_st_nxt = 3'h0;
    end
    irq_st_nxt = irq_st_nxt | ev;
  end

  // register all state
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      translator_hub_addr_r <= 7'h00;
      translator_port_num_r <= 7'h00;
      buffer_start_addr_r   <= 16'h0000;
      ufr_r                 <= 8'h00;
      act_r                 <= 1'b0;
      halt_r                <= 1'b0;
      bab_r                 <= 1'b0;
      xerr_r                <= 1'b0;
      split_phase_bit_r     <= 1'b0;
      toggle_bit_r          <= 1'b0;
      cerr_r                <= `SIDE_CERR_RST;
      bytes_done_count_r    <= 12'h000;
      res_r                 <= 24'h00_0000;
      start_split_mask_r    <= 8'h00;
      vld_r                 <= 1'b0;
      irq_st_r              <= 3'h0;
      irq_mk_r              <= 3'h0;
      ucnt_r                <= 14'h0000;
      slot_r                <= 3'h0;
      req_r                 <= 1'b0;
      rdata_r               <= 32'h0000_0000;
      st_r                  <= side_pkg::SIDE_IDLE;
    end else begin
      translator_hub_addr_r <= translator_hub_addr_nxt;
      translator_port_num_r <= translator_port_num_nxt;
      buffer_start_addr_r   <= buffer_start_addr_nxt;
      ufr_r                 <= ufr_nxt;
      act_r                 <= act_nxt;
      halt_r                <= halt_nxt;
      bab_r                 <= bab_nxt;
      xerr_r                <= xerr_nxt;
      split_phase_bit_r     <= split_phase_bit_nxt;
      toggle_bit_r          <= toggle_bit_nxt;
      cerr_r                <= cerr_nxt;
      bytes_done_count_r    <= bytes_done_count_nxt;
      res_r                 <= res_nxt;
      start_split_mask_r    <= start_split_mask_nxt;
      vld_r                 <= vld_nxt;
      irq_st_r              <= irq_st_nxt;
      irq_mk_r              <= irq_mk_nxt;
      ucnt_r                <= ucnt_nxt;
      slot_r                <= slot_nxt;
      req_r                 <= req_nxt;
      rdata_r               <= rdata_nxt;
      st_r                  <= st_nxt;
    end
  end

  // link-side request and interrupt outputs
  assign o_TXN_REQ      = req_r;
  assign o_TXN_COMPLETE = split_phase_bit_r;
  assign o_TXN_TOGGLE   = toggle_bit_r;
  assign o_TXN_HUB_ADDR = translator_hub_addr_r;
  assign o_TXN_PORT_NUM = translator_port_num_r;
  assign o_TXN_BUF_ADDR = buffer_start_addr_r;
  assign o_IRQ          = |(irq_st_r & irq_mk_r);

  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  sequence s_result;
    (st_r == side_pkg::SIDE_WAIT) && i_RES_VALID;
  endsequence
  sequence s_clean;
    s_result ##0 (!i_RES_STALL && !i_RES_BABBLE && !i_RES_ERR);
  endsequence

  property p_req_cause;
    o_TXN_REQ |-> $past(i_UFRAME_TICK) && $past(vld_r && act_r) &&
      st_r == side_pkg::SIDE_WAIT;
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("request without live descriptor and tick");

  property p_stall;
    s_result ##0 i_RES_STALL |=> halt_r && !act_r && !vld_r
      ##1 irq_st_r[`SIDE_IRQ_HALT];
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall did not halt and retire descriptor");

  property p_babble;
    bab_r == |{res_r[22], res_r[19], res_r[16], res_r[13],
               res_r[10], res_r[7], res_r[4], res_r[1]};
  endproperty
  a_babble: assert property (p_babble)
    else $error("babble flag differs from result fields");

  property p_retry;
    s_result ##0 (i_RES_ERR && !i_RES_STALL && !i_RES_BABBLE &&
      cerr_r > `SIDE_CERR_ONE) |=>
      cerr_r == $past(cerr_r) - `SIDE_CERR_ONE && act_r && !xerr_r;
  endproperty
  a_retry: assert property (p_retry)
    else $error("failed try did not decrement counter");

  property p_exhaust;
    s_result ##0 (i_RES_ERR && !i_RES_STALL && !i_RES_BABBLE &&
      cerr_r <= `SIDE_CERR_ONE) |=> xerr_r && cerr_r == 2'h0 && !act_r;
  endproperty
  a_exhaust: assert property (p_exhaust)
    else $error("exhausted retries not reported");

  property p_start_ok;
    s_clean ##0 !split_phase_bit_r |=>
      split_phase_bit_r && !start_split_mask_r[$past(slot_r)] && act_r;
  endproperty
  a_start_ok: assert property (p_start_ok)
    else $error("start split did not advance phase");

  property p_complete_ok;
    s_clean ##0 split_phase_bit_r |=> toggle_bit_r != $past(toggle_bit_r)
      && bytes_done_count_r == $past(i_RES_BYTES) && !vld_r;
  endproperty
  a_complete_ok: assert property (p_complete_ok)
    else $error("complete split did not finish descriptor");

  property p_poll;
    o_TXN_REQ |-> ($past(ucnt_r[7:0]) & poll_mask(ufr_r)) == 8'h00;
  endproperty
  a_poll: assert property (p_poll)
    else $error("request outside polling slot");
endmodule

// File: verif/side_hub_model.sv
`timescale 1ns/100ps
module side_hub_model (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_req,
  input  wire logic [2:0]  i_delay,
  input  wire logic [3:0]  i_fault,
  input  wire logic [11:0] i_bytes,
  output logic             o_valid,
  output logic      [3:0]  o_flags,
  output logic      [11:0] o_bytes
);
  logic [3:0] wait_r;
  // answer each split after the commanded delay; flags are err, babble,
  // underrun, stall; between answers the lines carry inverted junk so
  // nothing can lean on a stale value
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_r  <= 4'h0;
      o_valid <= 1'b0;
      o_flags <= 4'h0;
      o_bytes <= 12'h000;
    end else begin
      o_valid <= 1'b0;
      o_flags <= ~o_flags;
      o_bytes <= ~o_bytes;
      if (i_req) begin
        wait_r <= {1'b0, i_delay} + 4'h1;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
        if (wait_r == 4'h1) begin
          o_valid <= 1'b1;
          o_flags <= i_fault;
          o_bytes <= i_bytes;
        end
      end
    end
  end
endmodule

// File: verif/split_interrupt_descriptor_exec_tb.sv
`timescale 1ns/100ps
`include "side_consts.svh"
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
  end \
end
module split_interrupt_descriptor_exec_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        tick, tick_en, req, cpl, tgl, irq, r_valid;
  logic [11:0] paddr, r_bytes, p_bytes, last_n;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  o_hub, o_port, rh, rp;
  logic [15:0] o_buf, rb;
  logic [3:0]  r_flags, p_fault;
  logic [2:0]  p_delay;
  int          bad_count, total_checks, seed, tick_cnt, t0;

  side_exec i_dut (
    .I_CLK_SYS(clk), .I_RESETN(rst_n), .i_PSEL(psel),
    .i_PENABLE(penable), .i_PWRITE(pwrite), .i_PADDR(paddr),
    .i_PWDATA(pwdata), .o_PRDATA(prdata), .o_PREADY(pready),
    .o_PSLVERR(pslverr), .i_UFRAME_TICK(tick), .i_RES_VALID(r_valid),
    .i_RES_ERR(r_flags[0]), .i_RES_BABBLE(r_flags[1]),
    .i_RES_UNDERRUN(r_flags[2]), .i_RES_STALL(r_flags[3]),
    .i_RES_BYTES(r_bytes), .o_TXN_REQ(req), .o_TXN_COMPLETE(cpl),
    .o_TXN_TOGGLE(tgl), .o_TXN_HUB_ADDR(o_hub), .o_TXN_PORT_NUM(o_port),
    .o_TXN_BUF_ADDR(o_buf), .o_IRQ(irq));

  side_hub_model i_hub (
    .i_clk(clk), .i_resetn(rst_n), .i_req(req), .i_delay(p_delay),
    .i_fault(p_fault), .i_bytes(p_bytes), .o_valid(r_valid),
    .o_flags(r_flags), .o_bytes(r_bytes));

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // microframe pulse every 20 cycles, counted for the polling checks
  initial begin
    tick = 1'b0;
    tick_cnt = 0;
    forever begin
      repeat (19) @(posedge clk);
      tick <= tick_en;
      if (tick_en) tick_cnt++;
      @(posedge clk);
      tick <= 1'b0;
    end
  end

  // expected descriptor execution word
  function automatic logic [31:0] ex_w(logic h, b, x, sc, dt,
                                      logic [1:0] ce, logic [11:0] n);
    ex_w = {1'b0, h, b, x, sc, 1'b0, dt, ce, 11'h000, n};
  endfunction

  // microframes between runs for a frame field
  function automatic int poll_gap(logic [7:0] fr);
    poll_gap = 1;
    for (int j = 3; j < 8; j++) begin
      if (fr[j]) poll_gap = 1 << j;
    end
  endfunction

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // wait for a split request under a bound
  task automatic wait_req(input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req !== 1'b1 && n < lim);
    `CHK(req, 1'b1)
  endtask

  // load and hand over a descriptor
  task automatic arm(input logic dt, input logic [3:0] f,
                     input logic [7:0] fr);
    rh = dt ? 7'($random(seed)) : 7'h00;
    rp = 7'($random(seed));
    rb = 16'($random(seed));
    wr(`SIDE_OFF_BUF, {8'h00, rb, fr});
    wr(`SIDE_OFF_XLAT, {rh, rp, 18'h00000});
    wr(`SIDE_OFF_USTAT, 32'h0000_00FF);
    wr(`SIDE_OFF_EXEC, 32'h8180_0000 | {6'h00, dt, 25'h0000000});
    p_fault <= f;
    p_delay <= 3'($random(seed) & 3);
    wr(`SIDE_OFF_CTRL, 32'h0000_0001);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #(30000 * 50);
    bad_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    seed = 9727;
    bad_count = 0;
    total_checks = 0;
    last_n = 12'h000;
    {rst_n, psel, penable, pwrite, tick_en} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    p_fault = 4'h0;
    p_delay = 3'h0;
    p_bytes = 12'h000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    tick_en <= 1'b1;
    rdr(`SIDE_OFF_EXEC);
    `CHK(rd, ex_w(0, 0, 0, 0, 0, 2'h3, 12'h000))
    `CHK(irq, 1'b0)
    rdr(12'h01C);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    $display("test reset done");
    wr(`SIDE_OFF_IRQ_MASK, 32'h0000_0007);
    for (int i = 0; i < 2; i++) begin
      p_bytes <= 12'($random(seed));
      arm(i[0], i[0] ? 4'h4 : 4'h0, 8'h00);
      wait_req(60);
      `CHK({cpl, tgl}, {1'b0, i[0]})
      `CHK({o_hub, o_port, o_buf}, {rh, rp, rb})
      wait_req(60);
      `CHK(cpl, 1'b1)
      repeat (8) @(negedge clk);
      `CHK(irq, 1'b1)
      last_n = p_bytes;
      rdr(`SIDE_OFF_EXEC);
      `CHK(rd, ex_w(0, 0, 0, 1, ~i[0], 2'h3, last_n))
      rdr(`SIDE_OFF_USTAT);
      `CHK($onehot(~rd[7:0]), 1'b1)
      `CHK(|(rd[31:8] & 24'h924924), i[0])
      rdr(`SIDE_OFF_CTRL);
      `CHK(rd[0], 1'b0)
      rdr(`SIDE_OFF_IRQ_STAT);
      `CHK(rd[2:0], 3'h1)
      rdr(`SIDE_OFF_IRQ_STAT);
      `CHK({irq, rd[2:0]}, 4'h0)
    end
    $display("test clean split done");
    arm(1'b0, 4'h1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wait_req(60);
      `CHK(cpl, 1'b0)
      repeat (8) @(negedge clk);
      rdr(`SIDE_OFF_EXEC);
      `CHK(rd[24:23], 2'(2 - i))
    end
    `CHK(rd, ex_w(0, 0, 1, 0, 0, 2'h0, last_n))
    rdr(`SIDE_OFF_USTAT);
    `CHK(|(rd[31:8] & 24'h249249), 1'b1)
    rdr(`SIDE_OFF_IRQ_STAT);
    `CHK(rd[2:0], 3'h4)
    $display("test retry done");
    for (int k = 0; k < 2; k++) begin
      wr(`SIDE_OFF_IRQ_MASK, k ? 32'h0000_0007 : 32'h0000_0000);
      arm(1'b1, k ? 4'h2 : 4'h8, 8'h00);
      wait_req(60);
      repeat (8) @(negedge clk);
      `CHK(irq, k[0])
      rdr(`SIDE_OFF_EXEC);
      `CHK(rd, ex_w(1, k[0], 0, 0, 1, 2'h3, last_n))
      rdr(`SIDE_OFF_USTAT);
      `CHK(|(rd[31:8] & 24'h492492), k[0])
      rdr(`SIDE_OFF_IRQ_STAT);
      `CHK(rd[2:0], 3'h2)
    end
    $display("test halt done");
    for (int k = 3; k < 8; k++) begin
      arm(1'b0, 4'h0, 8'(1 << k));
      wait_req(6000);
      t0 = tick_cnt;
      wait_req(6000);
      `CHK(tick_cnt - t0, poll_gap(8'(1 << k)))
      repeat (8) @(negedge clk);
    end
    $display("test polling done");
    wrap_up();
  end
endmodule
